// ### hw/bmr_pkg.sv
// Constants and types for the boot mode reset controller
package bmr_pkg;

   // Clock and timing
   localparam int unsigned BMR_CLK_HZ = 100_000_000;
   localparam int unsigned BMR_CLK_PER_MS = BMR_CLK_HZ / 1000;
   localparam int unsigned BMR_RESET_MS = 500;
   localparam int unsigned BMR_DEBOUNCE_MS = 10;
   // Strictly longer than the reset time, hence one extra cycle
   localparam int unsigned BMR_RESET_CYCLES =
      BMR_RESET_MS * BMR_CLK_PER_MS + 1;
   localparam int unsigned BMR_DEBOUNCE_CYCLES =
      BMR_DEBOUNCE_MS * BMR_CLK_PER_MS;
   localparam int unsigned BMR_NMI_CYCLES = 16;

   // Widths
   localparam int unsigned BMR_CNT_W = 26;
   localparam int unsigned BMR_DEB_W = 20;
   localparam int unsigned BMR_NMI_W = 5;
   localparam int unsigned BMR_MODE_W = 4;
   localparam int unsigned BMR_IN_N = 4;

   // Input slots in the synchroniser and debouncer
   localparam int unsigned BMR_IN_RST = 0;
   localparam int unsigned BMR_IN_BOOT = 1;
   localparam int unsigned BMR_IN_NMI = 2;
   localparam int unsigned BMR_IN_CTS = 3;

   // Mode presented on the mode pins in boot mode
   localparam logic [BMR_MODE_W-1:0] BMR_BOOT_MODE = 4'h0;

   typedef enum logic [1:0] {
      BMR_USER_RST,
      BMR_USER_RUN,
      BMR_BOOT_RST,
      BMR_BOOT_RUN
   } bmr_state_t;

   typedef struct packed {
      logic [BMR_IN_N-1:0] sync1;
      logic [BMR_IN_N-1:0] sync2;
      logic [BMR_IN_N-1:0] act;
      logic [BMR_IN_N-1:0][BMR_DEB_W-1:0] deb_cnt;
      bmr_state_t state;
      logic [BMR_CNT_W-1:0] rst_cnt;
      logic [BMR_NMI_W-1:0] nmi_cnt;
      logic mcu_rst_n;
      logic mode_oe_n;
      logic rts;
      logic nmi_n;
   } bmr_regs_t;

endpackage

// ### hw/bmr_ctrl.sv
// Boot mode reset controller: reset timer, mode pins, NMI, mode feedback
//
// What this block does
// - After power-up the microcontroller reset is held for a timed interval.
// - When the power-up interval ends, reset is released in user mode.
// - In user run, an NMI button press gives one debounced pulse unless a pulse is running.
// - Boot press in user run resets with boot settings driven on mode pins.
// - A boot press during an ordinary reset interval does not enter boot.
// - The boot mode value is fixed at mode zero.
// - Mode pins are driven through outputs that can go high impedance.
// - Every reset interval lasts longer than 500 ms.
// - A new boot or reset press during an interval restarts the timer.
// - The controller is a four-state machine, reset and run per mode.
// - Reset holds while the control input is active, then about 500 ms.
// - First state holds reset; on expiry the run state keeps the mode.
// - Run states wait for a control input to pick user or boot reset.
// - Each low activation of the change request in a run state toggles boot and user.
// - The mode feedback line is high in boot mode and low in user mode.
`timescale 1ns/100ps

module bmr_ctrl
   import bmr_pkg::*;
#(
   parameter int unsigned RESET_CYCLES = BMR_RESET_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES = BMR_DEBOUNCE_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Push buttons, active low
   input wire logic rst_btn_n_i,
   input wire logic boot_btn_n_i,
   input wire logic nmi_btn_n_i,
   // Serial change request, active low
   input wire logic cts_n_i,
   // Microcontroller side
   output logic mcu_rst_n_o,
   output logic nmi_n_o,
   output logic [BMR_MODE_W-1:0] mode_o,
   output logic mode_oe_n_o,
   // Mode feedback
   output logic rts_o
);

   localparam bmr_regs_t REGS_RST = '{
      sync1: '0,
      sync2: '0,
      act: '0,
      deb_cnt: '0,
      state: BMR_USER_RST,
      rst_cnt: '0,
      nmi_cnt: '0,
      mcu_rst_n: 1'b0,
      mode_oe_n: 1'b1,
      rts: 1'b0,
      nmi_n: 1'b1
   };

   localparam logic [BMR_CNT_W-1:0] RST_LAST =
      BMR_CNT_W'(RESET_CYCLES - 1);
   localparam logic [BMR_DEB_W-1:0] DEB_LAST =
      BMR_DEB_W'(DEBOUNCE_CYCLES - 1);
   localparam logic [BMR_NMI_W-1:0] NMI_LEN = BMR_NMI_W'(BMR_NMI_CYCLES);

   bmr_regs_t r_ff;
   bmr_regs_t nxt_r;

   // Single-cycle presses from the debouncers
   // Each press is one cycle wide
   logic [BMR_IN_N-1:0] press;
   logic rst_req;
   logic boot_req;
   logic nmi_req;

   // Reset timer control
   logic hold;
   logic tmr_clear;
   logic tmr_done;

   // NMI pulse control
   logic nmi_allowed;
   logic nmi_busy;
   logic nmi_start;

   always_comb begin
      // Defaults: keep state, no events
      nxt_r = r_ff;
      press = '0;
      rst_req = 1'h0;
      boot_req = 1'h0;
      nmi_req = 1'h0;
      hold = 1'h0;
      tmr_clear = 1'h0;
      tmr_done = 1'h0;
      nmi_allowed = 1'h0;
      nmi_busy = 1'h0;
      nmi_start = 1'h0;

      // two-flop synchroniser
      // Inverted so that an active pin reads as one
      nxt_r.sync1[BMR_IN_RST] = ~rst_btn_n_i;
      nxt_r.sync1[BMR_IN_BOOT] = ~boot_btn_n_i;
      nxt_r.sync1[BMR_IN_NMI] = ~nmi_btn_n_i;
      nxt_r.sync1[BMR_IN_CTS] = ~cts_n_i;
      nxt_r.sync2 = r_ff.sync1;

      // debounce each input
      // Level must differ for the whole window
      for (int i = 0; i < BMR_IN_N; i++) begin
         if (r_ff.sync2[i] != r_ff.act[i]) begin
            if (r_ff.deb_cnt[i] == DEB_LAST) begin
               nxt_r.act[i] = r_ff.sync2[i];
               nxt_r.deb_cnt[i] = '0;
               // Only the active edge is a press
               press[i] = r_ff.sync2[i];
            end else begin
               nxt_r.deb_cnt[i] = r_ff.deb_cnt[i] + 1'h1;
            end
         end else begin
            // Bounce shorter than the window is dropped
            nxt_r.deb_cnt[i] = '0;
         end
      end

      // Requests seen by the state machine
      rst_req = press[BMR_IN_RST];
      nmi_req = press[BMR_IN_NMI];
      // change request acts like the boot button
      boot_req = press[BMR_IN_BOOT] | press[BMR_IN_CTS];

      // active control input holds the timer
      // Release starts the full interval again
      hold = r_ff.act[BMR_IN_RST] |
         r_ff.act[BMR_IN_BOOT] |
         r_ff.act[BMR_IN_CTS];

      tmr_clear = hold |
         rst_req |
         boot_req;

      // expire only past the minimum
      // One cycle beyond the minimum is counted
      tmr_done = (r_ff.rst_cnt == RST_LAST);

      case (r_ff.state)
         // Power-up and reset button land here
         BMR_USER_RST: begin
            if (tmr_clear) begin
               nxt_r.rst_cnt = '0;
            end else if (tmr_done) begin
               nxt_r.rst_cnt = '0;
               // user reset ends in user run
               // boot press here keeps user mode
               nxt_r.state = BMR_USER_RUN;
            end else begin
               // Count while no control input is active
               nxt_r.rst_cnt = r_ff.rst_cnt + 1'h1;
            end
         end

         // Boot settings are driven meanwhile
         BMR_BOOT_RST: begin
            if (tmr_clear) begin
               nxt_r.rst_cnt = '0;
            end else if (tmr_done) begin
               nxt_r.rst_cnt = '0;
               // run state keeps the boot mode
               nxt_r.state = BMR_BOOT_RUN;
            end else begin
               // Count while no control input is active
               nxt_r.rst_cnt = r_ff.rst_cnt + 1'h1;
            end
         end

         // Program runs with jumper mode
         BMR_USER_RUN: begin
            nxt_r.rst_cnt = '0;
            // wait for control input
            // Reset press wins over boot press
            if (rst_req) begin
               nxt_r.state = BMR_USER_RST;
            end else if (boot_req) begin
               nxt_r.state = BMR_BOOT_RST;
            end else begin
               nxt_r.state = BMR_USER_RUN;
            end
         end

         // Boot loader runs
         BMR_BOOT_RUN: begin
            nxt_r.rst_cnt = '0;
            // a further request toggles back to user
            if (rst_req || boot_req) begin
               nxt_r.state = BMR_USER_RST;
            end else begin
               nxt_r.state = BMR_BOOT_RUN;
            end
         end

         default: begin
            // Unused codes recover to user reset
            nxt_r.rst_cnt = '0;
            nxt_r.state = BMR_USER_RST;
         end
      endcase

      // NMI only while user run continues
      nmi_allowed = (r_ff.state == BMR_USER_RUN) &&
         (nxt_r.state == BMR_USER_RUN);
      nmi_busy = (r_ff.nmi_cnt != '0);
      // Presses during a running pulse are dropped
      nmi_start = nmi_allowed && nmi_req &&
         !nmi_busy;

      if (!nmi_allowed) begin
         // Leaving user run cuts the pulse
         nxt_r.nmi_cnt = '0;
      end else if (nmi_start) begin
         nxt_r.nmi_cnt = NMI_LEN;
      end else if (nmi_busy) begin
         nxt_r.nmi_cnt = r_ff.nmi_cnt - 1'h1;
      end else begin
         nxt_r.nmi_cnt = '0;
      end
      if (nxt_r.nmi_cnt != '0) begin
         nxt_r.nmi_n = 1'h0;
      end else begin
         nxt_r.nmi_n = 1'h1;
      end

      // Output levels follow the next state
      case (nxt_r.state)
         BMR_USER_RST: begin
            // power-up starts here with reset held
            nxt_r.mcu_rst_n = 1'h0;
            nxt_r.mode_oe_n = 1'h1;
            nxt_r.rts = 1'h0;
         end

         BMR_USER_RUN: begin
            nxt_r.mcu_rst_n = 1'h1;
            nxt_r.mode_oe_n = 1'h1;
            nxt_r.rts = 1'h0;
         end

         BMR_BOOT_RST: begin
            nxt_r.mcu_rst_n = 1'h0;
            nxt_r.mode_oe_n = 1'h0;
            nxt_r.rts = 1'h1;
         end

         BMR_BOOT_RUN: begin
            nxt_r.mcu_rst_n = 1'h1;
            // buffers stay enabled in boot run
            nxt_r.mode_oe_n = 1'h0;
            nxt_r.rts = 1'h1;
         end

         default: begin
            // Unused codes behave as user reset
            nxt_r.mcu_rst_n = 1'h0;
            nxt_r.mode_oe_n = 1'h1;
            nxt_r.rts = 1'h0;
         end
      endcase
   end

   // Synchronous reset is the power-up detect
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         r_ff <= REGS_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Registered outputs; the mode value is a constant
   assign mcu_rst_n_o = r_ff.mcu_rst_n;
   assign nmi_n_o = r_ff.nmi_n;
   // value applied only while enable is low
   assign mode_o = BMR_BOOT_MODE;
   assign mode_oe_n_o = r_ff.mode_oe_n;
   assign rts_o = r_ff.rts;

endmodule // bmr_ctrl

// ### verification/bmr_ctrl_properties.sv
// Port-level checks on the boot mode reset controller
`timescale 1ns/100ps
module bmr_ctrl_chk
   import bmr_pkg::*;
#(
   parameter int unsigned RESET_CYCLES = BMR_RESET_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic rst_btn_n_i,
   input wire logic mcu_rst_n_o,
   input wire logic nmi_n_o,
   input wire logic [BMR_MODE_W-1:0] mode_o,
   input wire logic mode_oe_n_o,
   input wire logic rts_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_nmi_low; !nmi_n_o[*8] ##1 !nmi_n_o[*8] ##1 nmi_n_o; endsequence
   sequence s_boot_rst; !mcu_rst_n_o && !mode_oe_n_o && $past(mcu_rst_n_o);
   endsequence
   property p_oe_rts; mode_oe_n_o == !rts_o; endproperty
   a_oe_rts: assert property (p_oe_rts) else $error("oe vs rts");
   property p_mode_zero; !mode_oe_n_o |-> mode_o == 4'h0; endproperty
   a_mode_zero: assert property (p_mode_zero) else $error("mode");
   property p_nmi_len; $fell(nmi_n_o) |-> s_nmi_low; endproperty
   a_nmi_len: assert property (p_nmi_len) else $error("nmi len");
   property p_rel_len;
      $rose(mcu_rst_n_o) |-> !$past(mcu_rst_n_o, RESET_CYCLES);
   endproperty
   a_rel_len: assert property (p_rel_len) else $error("short rst");
   property p_rst_btn; !rst_btn_n_i[*8] |-> ##[0:3] !mcu_rst_n_o; endproperty
   a_rst_btn: assert property (p_rst_btn) else $error("rst btn");
   property p_boot_entry; $rose(rts_o) |-> s_boot_rst; endproperty
   a_boot_entry: assert property (p_boot_entry) else $error("boot");
   property p_run_keeps;
      $rose(mcu_rst_n_o) |-> $stable(rts_o) && $stable(mode_oe_n_o);
   endproperty
   a_run_keeps: assert property (p_run_keeps) else $error("run");
   property p_boot_exit; $fell(rts_o) |-> !mcu_rst_n_o; endproperty
   a_boot_exit: assert property (p_boot_exit) else $error("exit");
endmodule // bmr_ctrl_chk
bind bmr_ctrl bmr_ctrl_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
   .sys_clk_i, .rst_n_i, .rst_btn_n_i, .mcu_rst_n_o, .nmi_n_o, .mode_o,
   .mode_oe_n_o, .rts_o);

// ### verification/bmr_mcu_model.sv
// Microcontroller model: latches mode pins at reset release, counts NMIs
`timescale 1ns/100ps
module bmr_mcu_model
   import bmr_pkg::*;
#(
   parameter logic [BMR_MODE_W-1:0] JUMPER_MODE = 4'h6
) (
   input wire logic mcu_rst_n_i,
   input wire logic nmi_n_i,
   input wire logic [BMR_MODE_W-1:0] mode_i,
   input wire logic mode_oe_n_i,
   output logic [BMR_MODE_W-1:0] mode_q_o,
   output logic [7:0] nmi_cnt_o = 8'h00
);
   always @(posedge mcu_rst_n_i) mode_q_o <= mode_oe_n_i ? JUMPER_MODE : mode_i;
   always @(negedge nmi_n_i) nmi_cnt_o <= nmi_cnt_o + 8'h01;
endmodule // bmr_mcu_model

// ### verification/tb_boot_mode_reset_controller.sv
// Self-checking bench for the boot mode reset controller
`timescale 1ns/100ps
module tb_boot_mode_reset_controller
   import bmr_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [BMR_IN_N-1:0] btn_n = 4'hf;
   logic mcu_rst_n, nmi_n, mode_oe_n, rts;
   logic [BMR_MODE_W-1:0] mode, mode_q;
   logic [7:0] nmi_cnt;
   int fail_count = 0, checked = 0, n;
   always #5 sys_clk = ~sys_clk;
   bmr_ctrl #(.RESET_CYCLES(20), .DEBOUNCE_CYCLES(4)) dut (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .rst_btn_n_i(btn_n[BMR_IN_RST]),
      .boot_btn_n_i(btn_n[BMR_IN_BOOT]), .nmi_btn_n_i(btn_n[BMR_IN_NMI]),
      .cts_n_i(btn_n[BMR_IN_CTS]), .mcu_rst_n_o(mcu_rst_n), .nmi_n_o(nmi_n),
      .mode_o(mode), .mode_oe_n_o(mode_oe_n), .rts_o(rts));
   bmr_mcu_model mcu (.mcu_rst_n_i(mcu_rst_n), .nmi_n_i(nmi_n), .mode_i(mode),
      .mode_oe_n_i(mode_oe_n), .mode_q_o(mode_q), .nmi_cnt_o(nmi_cnt));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic press(input int i);
      btn_n[i] = 1'b0;
      repeat (10) @(negedge sys_clk);
      btn_n[i] = 1'b1;
      repeat (10) @(negedge sys_clk);
   endtask
   task automatic wait_rel();
      n = 0;
      while (mcu_rst_n !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      chk(8'(mcu_rst_n), 8'h01);
   endtask
   task automatic give_verdict();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic glitch(input int i);
      btn_n[i] = 1'b0;
      repeat (2) @(negedge sys_clk);
      btn_n[i] = 1'b1;
      repeat (20) @(negedge sys_clk);
   endtask
   task automatic test_power_up();
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      chk(8'(mcu_rst_n), 8'h00);
      wait_rel();
      chk(8'(mode_q), 8'h06);
      chk(8'(mode_oe_n), 8'h01);
      $display("power-up test done");
   endtask
   task automatic test_nmi();
      press(BMR_IN_NMI);
      press(BMR_IN_NMI);
      repeat (20) @(negedge sys_clk);
      chk(nmi_cnt, 8'h02);
      glitch(BMR_IN_NMI);
      chk(nmi_cnt, 8'h02);
      chk(8'(nmi_n), 8'h01);
      $display("nmi test done");
   endtask
   task automatic test_boot();
      press(BMR_IN_BOOT);
      chk(8'(rts), 8'h01);
      chk(8'(mode_oe_n), 8'h00);
      chk(8'(mode), 8'h00);
      press(BMR_IN_BOOT);
      chk(8'(mcu_rst_n), 8'h00);
      wait_rel();
      chk(8'(mode_q), 8'h00);
      chk(8'(rts), 8'h01);
      press(BMR_IN_NMI);
      repeat (20) @(negedge sys_clk);
      chk(nmi_cnt, 8'h02);
      $display("boot test done");
   endtask
   task automatic test_return();
      press(BMR_IN_RST);
      chk(8'(rts), 8'h00);
      press(BMR_IN_BOOT);
      chk(8'(rts), 8'h00);
      wait_rel();
      chk(8'(mode_q), 8'h06);
      $display("return test done");
   endtask
   task automatic test_cts();
      press(BMR_IN_CTS);
      chk(8'(rts), 8'h01);
      wait_rel();
      press(BMR_IN_CTS);
      chk(8'(rts), 8'h00);
      wait_rel();
      $display("change request test done");
   endtask
   initial begin
      test_power_up();
      test_nmi();
      test_boot();
      test_return();
      test_cts();
      give_verdict();
   end
   initial begin
      #100us;
      fail_count++;
      give_verdict();
   end
endmodule // tb_boot_mode_reset_controller
